// file: src/css_defs.vh
// setting codes and operation mode encodings for the command source selector
`ifndef CSS_DEFS_VH
`define CSS_DEFS_VH
`define CSS_START_COMM      2'h0
`define CSS_START_EXT       2'h1
`define CSS_SPEED_COMM      2'h0
`define CSS_SPEED_EXT       2'h1
`define CSS_SPEED_EXT_COMMF 2'h2
`define CSS_NET_OPTION      14'h0000
`define CSS_NET_SERIAL      14'h0001
`define CSS_NET_AUTO        14'h270f
`define CSS_PANEL_SERIAL    2'h1
`define CSS_PANEL_LOCAL     2'h2
`define CSS_MODE_EXT        2'h0
`define CSS_MODE_PANEL      2'h1
`define CSS_MODE_NET        2'h2
`define CSS_OPSET_SWITCH    4'h0
`define CSS_RST_START       2'h0
`define CSS_RST_SPEED       2'h0
`define CSS_RST_NET         14'h270f
`define CSS_RST_PANEL       2'h2
`define CSS_SRC_NONE        2'h0
`define CSS_SRC_PANEL       2'h1
`define CSS_SRC_SERIAL      2'h2
`define CSS_SRC_OPTION      2'h3
`endif

// file: src/css_selector.v
// command source selector: settings, mode switching and per-port command gating
`timescale 1ns/1ps
`include "css_defs.vh"

// How it works
// - start source 0 takes run starts from communication, 1 from terminals
// - speed source 0 comm, 1 terminals, 2 terminals but comm frequency accepted
// - network source 0 takes network commands only from the option card
// - network source 1 takes network commands from serial terminals always
// - network source 9999 uses serial, or the option card when fitted
// - auto with option fitted rejects serial writes, starts, frequencies, except in panel mode with serial panel source; reads served
// - panel source 1 means serial terminals, 2 local panel, default 2
// - both selecting serial gives panel priority and refuses network entry
// - serial terminals refuse Modbus-RTU traffic while in panel mode
// - option as network source with no card refuses network mode entry
// - network/panel settings always writable; start/speed need group 0 or option
// - with mode setting 0, panel and network never switch directly
module css_selector (
    input  wire        mclk,
    input  wire        sys_rst,
    input  wire        option_fitted,
    input  wire [15:0] user_group_read_select,
    input  wire [3:0]  operation_mode_setting,
    input  wire        set_wr,
    input  wire [1:0]  set_sel,
    input  wire [13:0] set_data,
    output reg         set_refused,
    input  wire        mode_req,
    input  wire [1:0]  mode_req_target,
    output reg         mode_refused,
    output reg  [1:0]  op_mode,
    input  wire [2:0]  cmd_valid,
    input  wire [2:0]  cmd_is_write,
    input  wire [2:0]  cmd_is_start,
    input  wire [2:0]  cmd_is_freq,
    input  wire [2:0]  cmd_is_analog,
    input  wire        serial_modbus,
    output reg  [2:0]  cmd_accept,
    output reg  [2:0]  cmd_reject,
    output wire [2:0]  cmd_read_ok,
    input  wire        ext_start,
    input  wire        analog_freq_valid,
    output reg         start_from_ext,
    output reg         freq_from_ext,
    output reg         comm_freq_ok,
    output reg         analog_freq_ok,
    output reg  [1:0]  net_source,
    output reg  [1:0]  panel_source,
    output reg  [1:0]  start_source_select,
    output reg  [1:0]  speed_source_select,
    output reg  [13:0] network_mode_source_select,
    output reg  [1:0]  panel_mode_source_select
);
    // port index: 0 local panel, 1 serial terminals, 2 option card
    localparam [1:0] SEL_START = 2'h0;
    localparam [1:0] SEL_SPEED = 2'h1;
    localparam [1:0] SEL_NET   = 2'h2;
    localparam [1:0] SEL_PANEL = 2'h3;

    reg [1:0] next_net_source;
    reg [1:0] next_panel_source;
    reg [1:0] active_src;
    reg       set_ok;
    reg       mode_ok;
    reg       net_blocked;

    // resolve the network command source from the setting and card presence
    function [1:0] net_src_of;
        input [13:0] setting;
        input        fitted;
        begin
            case (setting)
                `CSS_NET_OPTION: net_src_of = `CSS_SRC_OPTION;
                `CSS_NET_SERIAL: net_src_of = `CSS_SRC_SERIAL;
                `CSS_NET_AUTO:   net_src_of = fitted ? `CSS_SRC_OPTION : `CSS_SRC_SERIAL;
                default:         net_src_of = `CSS_SRC_SERIAL;
            endcase
        end
    endfunction

    always @* begin
        next_net_source   = net_src_of(network_mode_source_select, option_fitted);
        next_panel_source = (panel_mode_source_select == `CSS_PANEL_SERIAL) ?
                            `CSS_SRC_SERIAL : `CSS_SRC_PANEL;
        // panel wins the shared serial port, so network entry is barred
        net_blocked = ((network_mode_source_select == `CSS_NET_SERIAL) &&
                       (panel_mode_source_select == `CSS_PANEL_SERIAL)) ||
                      ((next_net_source == `CSS_SRC_OPTION) && !option_fitted) ||
                      ((next_net_source == `CSS_SRC_SERIAL) &&
                       (next_panel_source == `CSS_SRC_SERIAL));
        case (op_mode)
            `CSS_MODE_PANEL: active_src = next_panel_source;
            `CSS_MODE_NET:   active_src = next_net_source;
            default:         active_src = `CSS_SRC_NONE;
        endcase
        // start/speed settings locked unless group 0 or a card is present
        case (set_sel)
            SEL_START: set_ok = (user_group_read_select == 16'h0000) || option_fitted;
            SEL_SPEED: set_ok = (user_group_read_select == 16'h0000) || option_fitted;
            SEL_NET:   set_ok = (set_data == `CSS_NET_OPTION) || (set_data == `CSS_NET_SERIAL) ||
                                (set_data == `CSS_NET_AUTO);
            default:   set_ok = (set_data == {12'h000, `CSS_PANEL_SERIAL}) ||
                                (set_data == {12'h000, `CSS_PANEL_LOCAL});
        endcase
        if (set_sel == SEL_START && set_data > 14'h0001)
            set_ok = 1'b0;
        if (set_sel == SEL_SPEED && set_data > 14'h0002)
            set_ok = 1'b0;
        case (mode_req_target)
            `CSS_MODE_EXT:   mode_ok = 1'b1;
            `CSS_MODE_PANEL: mode_ok = !((operation_mode_setting == `CSS_OPSET_SWITCH) &&
                                         (op_mode == `CSS_MODE_NET));
            `CSS_MODE_NET:   mode_ok = !net_blocked &&
                                       !((operation_mode_setting == `CSS_OPSET_SWITCH) &&
                                         (op_mode == `CSS_MODE_PANEL));
            default:         mode_ok = 1'b0;
        endcase
    end

    // read-type requests are always served on every port
    assign cmd_read_ok = cmd_valid & ~cmd_is_write & ~cmd_is_start & ~cmd_is_freq;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_port
            wire [1:0] port_src = (gi == 0) ? `CSS_SRC_PANEL :
                                  (gi == 1) ? `CSS_SRC_SERIAL : `CSS_SRC_OPTION;
            wire is_ctrl  = cmd_is_write[gi] | cmd_is_start[gi] | cmd_is_freq[gi];
            wire selected = (active_src == port_src);
            // serial port mutes control when auto mode sees a card, unless in panel mode with serial as panel source
            wire auto_mute = (gi == 1) && option_fitted &&
                             (network_mode_source_select == `CSS_NET_AUTO) &&
                             (op_mode != `CSS_MODE_PANEL || next_panel_source != `CSS_SRC_SERIAL);
            wire rtu_block = (gi == 1) && serial_modbus && (op_mode == `CSS_MODE_PANEL);
            // start honoured only if start source is communication (net mode)
            wire start_ok = !cmd_is_start[gi] || (op_mode != `CSS_MODE_NET) ||
                            (start_source_select == `CSS_START_COMM);
            wire freq_ok  = !cmd_is_freq[gi] || (op_mode != `CSS_MODE_NET) ||
                            (speed_source_select != `CSS_SPEED_EXT);
            wire ok = selected && !auto_mute && !rtu_block && start_ok && freq_ok;
            wire take = cmd_valid[gi] && is_ctrl && ok;
            wire drop = cmd_valid[gi] && (rtu_block || (is_ctrl && !ok));
        end
    endgenerate

    // one process owns both pulse vectors so each has a single driver
    always @(posedge mclk) begin
        if (sys_rst) begin
            cmd_accept <= 3'h0;
            cmd_reject <= 3'h0;
        end else begin
            cmd_accept <= {g_port[2].take, g_port[1].take, g_port[0].take};
            cmd_reject <= {g_port[2].drop, g_port[1].drop, g_port[0].drop};
        end
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            start_source_select        <= `CSS_RST_START;
            speed_source_select        <= `CSS_RST_SPEED;
            network_mode_source_select <= `CSS_RST_NET;
            panel_mode_source_select   <= `CSS_RST_PANEL;
            op_mode                    <= `CSS_MODE_EXT;
            set_refused                <= 1'b0;
            mode_refused               <= 1'b0;
            net_source                 <= `CSS_SRC_SERIAL;
            panel_source               <= `CSS_SRC_PANEL;
            start_from_ext             <= 1'b0;
            freq_from_ext              <= 1'b0;
            comm_freq_ok               <= 1'b0;
            analog_freq_ok             <= 1'b0;
        end else begin
            set_refused  <= set_wr && !set_ok;
            mode_refused <= mode_req && !mode_ok;
            if (set_wr && set_ok) begin
                case (set_sel)
                    SEL_START: start_source_select        <= set_data[1:0];
                    SEL_SPEED: speed_source_select        <= set_data[1:0];
                    SEL_NET:   network_mode_source_select <= set_data;
                    default:   panel_mode_source_select   <= set_data[1:0];
                endcase
            end
            if (mode_req && mode_ok)
                op_mode <= mode_req_target;
            else if (op_mode == `CSS_MODE_NET && net_blocked)
                op_mode <= `CSS_MODE_EXT;
            net_source     <= next_net_source;
            panel_source   <= next_panel_source;
            start_from_ext <= (start_source_select == `CSS_START_EXT) && ext_start;
            freq_from_ext  <= (speed_source_select != `CSS_SPEED_COMM);
            comm_freq_ok   <= (speed_source_select != `CSS_SPEED_EXT);
            analog_freq_ok <= (speed_source_select == `CSS_SPEED_EXT) && analog_freq_valid;
        end
    end
endmodule // css_selector

// file: sim/css_host_model.sv
// remote host model placing one command on a chosen port
`timescale 1ns/1ps
module css_host_model (
    input  wire       go,
    input  wire [1:0] port,
    input  wire [1:0] kind,
    input  wire       modbus,
    output wire [2:0] cmd_valid,
    output wire [2:0] cmd_is_write,
    output wire [2:0] cmd_is_start,
    output wire [2:0] cmd_is_freq,
    output wire       serial_modbus
);
    wire [2:0] sel = go ? (3'h1 << port) : 3'h0;
    assign cmd_valid = sel;
    assign cmd_is_write = (kind == 2'h1) ? sel : 3'h0;
    assign cmd_is_start = (kind == 2'h2) ? sel : 3'h0;
    assign cmd_is_freq = (kind == 2'h3) ? sel : 3'h0;
    // modbus only when the bench asks, passed straight through to serial_modbus
    assign serial_modbus = modbus;
endmodule // css_host_model

// file: sim/css_selector_props.sv
// assertions on the command source selector ports
`timescale 1ns/1ps
module css_selector_chk (
    input wire        mclk,
    input wire        sys_rst,
    input wire        option_fitted,
    input wire [3:0]  operation_mode_setting,
    input wire        set_wr,
    input wire [1:0]  set_sel,
    input wire [13:0] set_data,
    input wire        set_refused,
    input wire        mode_req,
    input wire [1:0]  mode_req_target,
    input wire        mode_refused,
    input wire [1:0]  op_mode,
    input wire [2:0]  cmd_valid,
    input wire [2:0]  cmd_is_write,
    input wire        serial_modbus,
    input wire [2:0]  cmd_reject,
    input wire [1:0]  net_source,
    input wire [13:0] network_mode_source_select,
    input wire [1:0]  panel_mode_source_select
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence net_req;
        mode_req && mode_req_target == 2'h2;
    endsequence
    net_write_a: assert property (set_wr && set_sel == 2'h2 && set_data == 14'h0001
        |=> !set_refused && network_mode_source_select == 14'h0001) else $error("net write lost");
    no_card_a: assert property (net_req ##0 (network_mode_source_select == 14'h0 && !option_fitted)
        |=> mode_refused && op_mode != 2'h2) else $error("net entry without card");
    both_serial_a: assert property (net_req ##0 (network_mode_source_select == 14'h1
        && panel_mode_source_select == 2'h1) |=> mode_refused) else $error("net entry not refused");
    no_direct_a: assert property (net_req ##0 (operation_mode_setting == 4'h0 && op_mode == 2'h1)
        |=> mode_refused && op_mode == 2'h1) else $error("direct panel to net");
    auto_reject_a: assert property (cmd_valid[1] && cmd_is_write[1] && op_mode == 2'h2 && option_fitted
        && network_mode_source_select == 14'h270f |=> cmd_reject[1]) else $error("serial write taken");
    modbus_block_a: assert property (cmd_valid[1] && serial_modbus && op_mode == 2'h1
        |=> cmd_reject[1]) else $error("modbus in panel mode");
    serial_src_a: assert property ((network_mode_source_select == 14'h1)[*2]
        |-> net_source == 2'h2) else $error("net source not serial");
    option_src_a: assert property ((network_mode_source_select == 14'h0)[*2]
        |-> net_source == 2'h3) else $error("net source not option");
endmodule // css_selector_chk
bind css_selector css_selector_chk chk_u (.mclk(mclk), .sys_rst(sys_rst), .option_fitted(option_fitted),
    .operation_mode_setting(operation_mode_setting), .set_wr(set_wr), .set_sel(set_sel), .set_data(set_data),
    .set_refused(set_refused), .mode_req(mode_req), .mode_req_target(mode_req_target),
    .mode_refused(mode_refused), .op_mode(op_mode), .cmd_valid(cmd_valid), .cmd_is_write(cmd_is_write),
    .serial_modbus(serial_modbus), .cmd_reject(cmd_reject), .net_source(net_source),
    .network_mode_source_select(network_mode_source_select),
    .panel_mode_source_select(panel_mode_source_select));

// file: sim/test_css_selector.sv
// self-checking bench for the command source selector
`timescale 1ns/1ps
`include "css_defs.vh"
module test_css_selector;
    reg         mclk = 1'b0;
    reg         rst = 1'b1;
    reg         opt = 1'b0;
    reg  [15:0] ugrp = 16'h0;
    reg         swr = 1'b0;
    reg  [1:0]  ssel = 2'h0;
    reg  [13:0] sdat = 14'h0;
    reg         mreq = 1'b0;
    reg  [1:0]  tgt = 2'h0;
    reg         go = 1'b0;
    reg  [1:0]  port = 2'h0;
    reg  [1:0]  kind = 2'h0;
    reg         mb = 1'b0;
    reg         ext = 1'b0;
    reg         ana = 1'b0;
    reg  [3:0]  opset = 4'h0;
    wire [2:0]  cv, cw, cs, cf, acc, rej, rdok;
    wire        srl, sref, mref, sfe, ffe, cfo, afo;
    wire [1:0]  op_mode, nsrc, psrc, ssrc, spsrc, psel;
    wire [13:0] nsel;
    integer     n_mismatch = 0;
    integer     comparisons = 0;
    integer     cyc = 0;
    css_selector dut_u (.mclk(mclk), .sys_rst(rst), .option_fitted(opt), .user_group_read_select(ugrp),
        .operation_mode_setting(opset), .set_wr(swr), .set_sel(ssel), .set_data(sdat), .set_refused(sref),
        .mode_req(mreq), .mode_req_target(tgt), .mode_refused(mref), .op_mode(op_mode), .cmd_valid(cv),
        .cmd_is_write(cw), .cmd_is_start(cs), .cmd_is_freq(cf), .cmd_is_analog(3'h0), .serial_modbus(srl),
        .cmd_accept(acc), .cmd_reject(rej), .cmd_read_ok(rdok), .ext_start(ext), .analog_freq_valid(ana),
        .start_from_ext(sfe), .freq_from_ext(ffe), .comm_freq_ok(cfo), .analog_freq_ok(afo), .net_source(nsrc),
        .panel_source(psrc), .start_source_select(ssrc), .speed_source_select(spsrc),
        .network_mode_source_select(nsel), .panel_mode_source_select(psel));
    css_host_model host_u (.go(go), .port(port), .kind(kind), .modbus(mb), .cmd_valid(cv), .cmd_is_write(cw),
        .cmd_is_start(cs), .cmd_is_freq(cf), .serial_modbus(srl));
    initial forever #20 mclk = ~mclk;
    task step(); @(posedge mclk); #1; endtask
    task chk(input [31:0] seen, input [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input [1:0] s, input [13:0] d, input e);
        swr = 1'b1;
        ssel = s;
        sdat = d;
        step();
        chk(sref, e);
        swr = 1'b0;
        step();
    endtask
    task req(input [1:0] t, input e);
        mreq = 1'b1;
        tgt = t;
        step();
        chk(mref, e);
        mreq = 1'b0;
        step();
    endtask
    // kind 0 read, 1 write, 2 start, 3 frequency; reads judged by read_ok and reject, not by accept
    task cmd(input [1:0] p, input [1:0] k, input m, input a);
        go = 1'b1;
        port = p;
        kind = k;
        mb = m;
        #2 chk(rdok[p], k == 2'h0);
        step();
        chk(rej[p], !a);
        if (k != 2'h0)
            chk(acc[p], a);
        go = 1'b0;
        step();
    endtask
    task print_verdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // external start and frequency routing, and their effect on net-mode commands
    task source_outputs();
        ext = 1'b1;
        ana = 1'b1;
        wr(2'h0, 14'h1, 1'b0);
        chk(sfe, 1'b1);
        cmd(2'h2, 2'h2, 1'b0, 1'b0);
        wr(2'h1, 14'h1, 1'b0);
        chk({ffe, cfo, afo}, 3'h5);
        cmd(2'h2, 2'h3, 1'b0, 1'b0);
        wr(2'h1, 14'h2, 1'b0);
        chk({ffe, cfo, afo}, 3'h6);
        cmd(2'h2, 2'h3, 1'b0, 1'b1);
        ext = 1'b0;
        wr(2'h0, 14'h0, 1'b0);
        chk(sfe, 1'b0);
    endtask
    // direct panel/net switching with network entry otherwise allowed
    task mode_switch();
        req(`CSS_MODE_PANEL, 1'b1);
        chk(op_mode, `CSS_MODE_NET);
        opset = 4'h6;
        req(`CSS_MODE_PANEL, 1'b0);
        opset = 4'h0;
        req(`CSS_MODE_NET, 1'b1);
        chk(op_mode, `CSS_MODE_PANEL);
        opset = 4'h6;
        req(`CSS_MODE_NET, 1'b0);
        chk(op_mode, `CSS_MODE_NET);
    endtask
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            n_mismatch = n_mismatch + 1;
            print_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge mclk);
        #1 rst = 1'b0;
        chk({ssrc, spsrc, nsel, psel}, {`CSS_RST_START, `CSS_RST_SPEED, `CSS_RST_NET, `CSS_RST_PANEL});
        chk(nsrc, `CSS_SRC_SERIAL);
        chk(psrc, `CSS_SRC_PANEL);
        ugrp = 16'h0001;
        wr(2'h0, 14'h1, 1'b1);
        wr(2'h2, `CSS_NET_SERIAL, 1'b0);
        wr(2'h2, `CSS_NET_AUTO, 1'b0);
        opt = 1'b1;
        wr(2'h0, 14'h1, 1'b0);
        wr(2'h1, 14'h2, 1'b0);
        wr(2'h1, 14'h3, 1'b1);
        chk({ssrc, spsrc}, {`CSS_START_EXT, `CSS_SPEED_EXT_COMMF});
        wr(2'h0, 14'h0, 1'b0);
        wr(2'h1, 14'h0, 1'b0);
        opt = 1'b0;
        ugrp = 16'h0;
        req(`CSS_MODE_NET, 1'b0);
        cmd(2'h1, 2'h2, 1'b0, 1'b1);
        cmd(2'h0, 2'h2, 1'b0, 1'b0);
        opt = 1'b1;
        step();
        step();
        chk(nsrc, `CSS_SRC_OPTION);
        cmd(2'h1, 2'h1, 1'b0, 1'b0);
        cmd(2'h1, 2'h0, 1'b0, 1'b1);
        cmd(2'h2, 2'h3, 1'b0, 1'b1);
        opt = 1'b0;
        req(`CSS_MODE_EXT, 1'b0);
        wr(2'h2, `CSS_NET_SERIAL, 1'b0);
        wr(2'h3, `CSS_PANEL_SERIAL, 1'b0);
        chk(psrc, `CSS_SRC_SERIAL);
        req(`CSS_MODE_NET, 1'b1);
        req(`CSS_MODE_PANEL, 1'b0);
        cmd(2'h1, 2'h2, 1'b1, 1'b0);
        cmd(2'h1, 2'h2, 1'b0, 1'b1);
        cmd(2'h0, 2'h2, 1'b0, 1'b0);
        req(`CSS_MODE_NET, 1'b1);
        chk(op_mode, `CSS_MODE_PANEL);
        req(`CSS_MODE_EXT, 1'b0);
        wr(2'h3, `CSS_PANEL_LOCAL, 1'b0);
        wr(2'h2, `CSS_NET_OPTION, 1'b0);
        req(`CSS_MODE_NET, 1'b1);
        opt = 1'b1;
        step();
        step();
        req(`CSS_MODE_NET, 1'b0);
        cmd(2'h1, 2'h2, 1'b0, 1'b0);
        cmd(2'h2, 2'h2, 1'b0, 1'b1);
        source_outputs();
        mode_switch();
        print_verdict();
    end
endmodule // test_css_selector
